//--- common/fwp_pkg.sv
/*
 package of the flash write-protect and program/erase timing block.
 assumes a 40 MHz system clock and a mode 0/3 serial host.
*/
package fwp_pkg;
   localparam int CLK_MHZ = 40;
   // ************************************
   // timing
   // ************************************
   localparam int T_SUSP_MAX_US = 30;
   localparam int SUSP_CYC = T_SUSP_MAX_US * CLK_MHZ;
   localparam int T_PP_TYP_US = 1500;
   localparam int T_ER_TYP_US = 16000;
   localparam int T_CE_TYP_US = 80000;
   localparam int PP_CYC = T_PP_TYP_US * CLK_MHZ;
   localparam int ER_CYC = T_ER_TYP_US * CLK_MHZ;
   localparam int CE_CYC = T_CE_TYP_US * CLK_MHZ;
   // ************************************
   // serial commands
   // ************************************
   localparam logic [7:0] C_SET_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] C_WRDI = 8'h04;
   localparam logic [7:0] C_WRSR = 8'h01;
   localparam logic [7:0] C_PP = 8'h02;
   localparam logic [7:0] C_PE = 8'h81;
   localparam logic [7:0] C_SE = 8'h20;
   localparam logic [7:0] C_B32 = 8'h52;
   localparam logic [7:0] C_B64 = 8'hD8;
   localparam logic [7:0] C_CE = 8'hC7;
   localparam logic [7:0] C_DP = 8'hB9;
   localparam logic [7:0] C_RDP = 8'hAB;
   localparam logic [7:0] C_SUS = 8'h75;
   localparam logic [7:0] C_RES = 8'h7A;
   localparam logic [11:0] PP_MAX_BITS = 12'h820;
   // ************************************
   // status layout and sizes
   // ************************************
   localparam int SR_BP_LSB = 2;
   localparam int SR_STATUS_PROTECT_LO = 7;
   localparam int SR_STATUS_PROTECT_HI = 8;
   localparam int SR_CMP = 14;
   localparam logic [15:0] SR_RST = 16'h0000;
   localparam logic [15:0] SR_WR_MASK = 16'h41FC;
   localparam logic [15:0] SR_WP_MASK = 16'h01FC;
   localparam logic [20:0] SZ_MEM = 21'h100000;
   localparam logic [20:0] SZ_64K = 21'h010000;
   localparam logic [20:0] SZ_32K = 21'h008000;
   localparam logic [20:0] SZ_4K = 21'h001000;
   localparam logic [20:0] SZ_PAGE = 21'h000100;
   // ************************************
   // apb map
   // ************************************
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_CTRL = 8'h04;
   localparam logic [7:0] A_EVENT = 8'h08;
   localparam logic [7:0] A_PROT = 8'h0C;
   typedef enum logic [2:0] {
      OP_PROG = 3'b000, OP_PE = 3'b001, OP_SE = 3'b010,
      OP_B32 = 3'b011, OP_B64 = 3'b100, OP_CE = 3'b101
   } fwp_op_t;
   typedef enum logic [2:0] {
      ST_STBY = 3'b000, ST_BUSY = 3'b001, ST_SWAIT = 3'b010,
      ST_SUSP = 3'b011, ST_DPD = 3'b100
   } fwp_st_t;
endpackage

//--- rtl/fwp_flash_protect.sv
/*
 write protection and program/erase timing of a serial nor flash.
 assumes serial pins asynchronous to clk_sys, apb master on clk_sys.
*/
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module fwp_flash_protect #(
   parameter int PP_CYC = fwp_pkg::PP_CYC,
   parameter int ER_CYC = fwp_pkg::ER_CYC,
   parameter int CE_CYC = fwp_pkg::CE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   input wire logic wp_n,
   input wire logic sector_locked,
   output logic op_start,
   output fwp_pkg::fwp_op_t op_kind,
   output logic [19:0] op_addr,
   output logic op_done,
   output logic busy
);
   import fwp_pkg::*;

   // ************************************
   // functions
   // ************************************
   function automatic logic [20:0] kind_len(input fwp_op_t k);
      case (k)
         OP_PROG, OP_PE: kind_len = SZ_PAGE;
         OP_SE: kind_len = SZ_4K;
         OP_B32: kind_len = SZ_32K;
         OP_B64: kind_len = SZ_64K;
         default: kind_len = SZ_MEM;
      endcase
   endfunction

   // returns {lo, hi}, hi exclusive
   function automatic logic [41:0] region(input logic [4:0] bp, input logic cmp);
      logic [20:0] sz;
      logic all, none;
      sz = '0;
      all = 1'b0;
      none = 1'b0;
      if (bp[2:0] == 3'b000) begin
         none = 1'b1;
      end else if (bp[2] & bp[1]) begin
         all = 1'b1;
      end else if (!bp[4]) begin
         if (bp[2] & bp[0]) begin
            all = 1'b1;
         end else begin
            sz = SZ_64K << (bp[2:0] - 3'd1);
         end
      end else if (bp[2]) begin
         sz = SZ_32K;
      end else begin
         sz = SZ_4K << (bp[1:0] - 2'd1);
      end
      if (!cmp) begin
         if (none) region = '0;
         else if (all) region = {21'h0, SZ_MEM};
         else if (bp[3]) region = {21'h0, sz};
         else region = {SZ_MEM - sz, SZ_MEM};
      end else begin
         if (none) region = {21'h0, SZ_MEM};
         else if (all) region = '0;
         else if (bp[3]) region = {sz, SZ_MEM};
         else region = {21'h0, SZ_MEM - sz};
      end
   endfunction

   // ************************************
   // pin synchronisers
   // ************************************
   logic [1:0] cs_s_q, ck_s_q, si_s_q, wp_s_q;
   logic ck_d1_q, cs_d1_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cs_s_q <= 2'b11;
         ck_s_q <= 2'b00;
         si_s_q <= 2'b00;
         wp_s_q <= 2'b11;
         ck_d1_q <= 1'b0;
         cs_d1_q <= 1'b1;
      end else begin
         cs_s_q <= {cs_s_q[0], cs_n};
         ck_s_q <= {ck_s_q[0], sclk};
         si_s_q <= {si_s_q[0], si};
         wp_s_q <= {wp_s_q[0], wp_n};
         ck_d1_q <= ck_s_q[1];
         cs_d1_q <= cs_s_q[1];
      end
   end
   logic ck_rise, cmd_end;
   logic [7:0] nbyte;
   assign ck_rise = ck_s_q[1] & ~ck_d1_q & ~cs_s_q[1];
   assign cmd_end = cs_s_q[1] & ~cs_d1_q;

   // ************************************
   // bit counter and byte capture
   // ************************************
   logic [31:0] sh_q;
   logic [11:0] cnt_q;
   logic [7:0] opc_q, b1_q, b2_q;
   logic [19:0] adr_q;
   assign nbyte = {sh_q[6:0], si_s_q[1]};
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sh_q <= '0;
         cnt_q <= '0;
         opc_q <= '0;
         b1_q <= '0;
         b2_q <= '0;
         adr_q <= '0;
      end else if (cs_s_q[1]) begin
         cnt_q <= '0;
      end else if (ck_rise) begin
         sh_q <= {sh_q[30:0], si_s_q[1]};
         if (cnt_q != 12'hFFF) cnt_q <= cnt_q + 12'd1;
         if (cnt_q == 12'd7) opc_q <= nbyte;
         if (cnt_q == 12'd15) b1_q <= nbyte;
         if (cnt_q == 12'd23) b2_q <= nbyte;
         if (cnt_q == 12'd31) adr_q <= {sh_q[18:0], si_s_q[1]};
      end
   end

   // ************************************
   // command decision
   // ************************************
   logic [15:0] sreg_q;
   logic wel_q, wps_q;
   fwp_st_t st_q, st_d;
   logic [41:0] reg_lohi;
   logic [20:0] len, a_lo;
   logic hit, is_op, len_ok, byte_ok, valid;
   logic a_set_write_enable_cmd, a_wrdi, a_wrsr, a_op, a_dp, a_rdp, a_sus, a_res, rej;
   fwp_op_t kind;
   assign reg_lohi = region(sreg_q[SR_BP_LSB +: 5], sreg_q[SR_CMP]);
   assign len = kind_len(kind);
   assign a_lo = {1'b0, adr_q} & ~(len - 21'd1);
   always_comb begin
      kind = OP_PROG;
      is_op = 1'b1;
      len_ok = (cnt_q == 12'd32);
      case (opc_q)
         C_PP: len_ok = (cnt_q >= 12'd40) && (cnt_q <= PP_MAX_BITS);
         C_PE: kind = OP_PE;
         C_SE: kind = OP_SE;
         C_B32: kind = OP_B32;
         C_B64: kind = OP_B64;
         C_CE: begin
            kind = OP_CE;
            len_ok = (cnt_q == 12'd8);
         end
         C_WRSR: begin
            is_op = 1'b0;
            len_ok = (cnt_q == 12'd16) || (cnt_q == 12'd24);
         end
         default: begin
            is_op = 1'b0;
            len_ok = (cnt_q == 12'd8);
         end
      endcase
   end
   // region overlap, or lock bits under scheme one
   assign hit = wps_q ? sector_locked :
      ((a_lo < reg_lohi[20:0]) && ((a_lo + len) > reg_lohi[41:21]));
   assign byte_ok = (cnt_q[2:0] == 3'b000);
   assign valid = cmd_end & byte_ok & len_ok;
   always_comb begin
      a_set_write_enable_cmd = 1'b0;
      a_wrdi = 1'b0;
      a_wrsr = 1'b0;
      a_op = 1'b0;
      a_dp = 1'b0;
      a_rdp = 1'b0;
      a_sus = 1'b0;
      a_res = 1'b0;
      if (valid) begin
         case (st_q)
            ST_DPD: a_rdp = (opc_q == C_RDP);
            ST_BUSY: a_sus = (opc_q == C_SUS);
            ST_SUSP: begin
               a_res = (opc_q == C_RES);
               a_set_write_enable_cmd = (opc_q == C_SET_WRITE_ENABLE_CMD);
               a_wrdi = (opc_q == C_WRDI);
            end
            ST_STBY: begin
               a_set_write_enable_cmd = (opc_q == C_SET_WRITE_ENABLE_CMD);
               a_wrdi = (opc_q == C_WRDI);
               a_dp = (opc_q == C_DP);
               a_wrsr = (opc_q == C_WRSR) & wel_q;
               a_op = is_op & wel_q & ~hit;
            end
            default: ;
         endcase
      end
   end
   // a modifying command that ends but is not taken
   assign rej = cmd_end & (st_q != ST_DPD) & (is_op | (opc_q == C_WRSR)) & ~a_op & ~a_wrsr;

   // ************************************
   // control state and timers
   // ************************************
   logic [31:0] tmr_q;
   logic [10:0] sus_q;
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_STBY: begin
            if (a_op) st_d = ST_BUSY;
            else if (a_dp) st_d = ST_DPD;
         end
         ST_BUSY: begin
            if (a_sus) st_d = ST_SWAIT;
            else if (tmr_q == 32'd1) st_d = ST_STBY;
         end
         ST_SWAIT: if (sus_q == 11'd1) st_d = ST_SUSP;
         ST_SUSP: if (a_res) st_d = ST_BUSY;
         ST_DPD: if (a_rdp) st_d = ST_STBY;
         default: st_d = ST_STBY;
      endcase
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= ST_STBY;
         busy <= 1'b0;
         tmr_q <= '0;
         sus_q <= '0;
         op_start <= 1'b0;
         op_done <= 1'b0;
         op_kind <= OP_PROG;
         op_addr <= '0;
      end else begin
         st_q <= st_d;
         busy <= (st_d == ST_BUSY) || (st_d == ST_SWAIT);
         op_start <= a_op;
         op_done <= (st_q == ST_BUSY) && (st_d == ST_STBY);
         if (a_op) begin
            op_kind <= kind;
            op_addr <= a_lo[19:0];
            if (kind == OP_PROG) tmr_q <= PP_CYC;
            else if (kind == OP_CE) tmr_q <= CE_CYC;
            else tmr_q <= ER_CYC;
         end else if (st_q == ST_BUSY && !a_sus && tmr_q != 32'd0) begin
            tmr_q <= tmr_q - 32'd1;
         end
         if (a_sus) sus_q <= SUSP_CYC[10:0];
         else if (sus_q != 11'd0) sus_q <= sus_q - 11'd1;
      end
   end

   // ************************************
   // write-enable latch and status bits
   // ************************************
   logic [15:0] wmask;
   always_comb begin
      wmask = SR_WR_MASK;
      if (!wp_s_q[1]) wmask = wmask & ~SR_WP_MASK;
      if (cnt_q == 12'd16) wmask = wmask & 16'h00FF;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wel_q <= 1'b0;
      end else if (a_set_write_enable_cmd) begin
         wel_q <= 1'b1;
      end else if (a_wrdi || a_wrsr || rej || op_done) begin
         wel_q <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sreg_q <= SR_RST;
      end else if (a_wrsr) begin
         sreg_q <= (sreg_q & ~wmask) | ({b2_q, b1_q} & wmask);
      end
   end

   // ************************************
   // apb slave
   // ************************************
   logic acc_st_q, rej_st_q, map_ok, wr_now;
   logic [31:0] rd_d;
   assign wr_now = psel & penable & pready & pwrite;
   always_comb begin
      map_ok = 1'b1;
      rd_d = '0;
      case (paddr)
         A_STATUS: begin
            rd_d[15:0] = sreg_q;
            rd_d[0] = busy;
            rd_d[1] = wel_q;
            rd_d[18:16] = st_q;
         end
         A_CTRL: rd_d[0] = wps_q;
         A_EVENT: rd_d[1:0] = {acc_st_q, rej_st_q};
         A_PROT: rd_d = {2'b00, reg_lohi[41:28], 2'b00, reg_lohi[20:7]};
         default: map_ok = 1'b0;
      endcase
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~map_ok;
         if (psel & penable & ~pready) prdata <= pwrite ? 32'h0 : rd_d;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wps_q <= 1'b0;
      end else if (wr_now && paddr == A_CTRL) begin
         wps_q <= pwdata[0];
      end
   end
   // sticky events, set beats write-one clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rej_st_q <= 1'b0;
         acc_st_q <= 1'b0;
      end else begin
         if (rej) rej_st_q <= 1'b1;
         else if (wr_now && paddr == A_EVENT && pwdata[0]) rej_st_q <= 1'b0;
         if (a_op | a_wrsr) acc_st_q <= 1'b1;
         else if (wr_now && paddr == A_EVENT && pwdata[1]) acc_st_q <= 1'b0;
      end
   end
endmodule

//--- dv/fwp_props.sv
/* port checker of the flash protect block.
   assumes one clk_sys domain, bound to the top module. */
`timescale 1ns/10ps
module fwp_props
   import fwp_pkg::*;
#(
   parameter int PP_CYC = 2000,
   parameter int ER_CYC = 3000,
   parameter int CE_CYC = 4000
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic op_start,
   input fwp_pkg::fwp_op_t op_kind,
   input wire logic op_done,
   input wire logic busy
);
   int cnt_q;
   int lim;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ************
   // busy counter
   // ************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= 0;
      end else if (op_start) begin
         cnt_q <= 0;
      end else if (busy) begin
         cnt_q <= cnt_q + 1;
      end
   end
   assign lim = (op_kind == OP_PROG) ? PP_CYC : (op_kind == OP_CE) ? CE_CYC : ER_CYC;
   property p_ans;
      psel && penable && !pready |=> pready;
   endproperty
   a_ans: assert property (p_ans) else $error("late apb answer");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("lone pslverr");
   property p_start;
      op_start |-> ##[0:1] busy;
   endproperty
   a_start: assert property (p_start) else $error("no busy");
   property p_one;
      op_start |-> !$past(busy);
   endproperty
   a_one: assert property (p_one) else $error("start while busy");
   property p_done;
      op_done |-> $past(busy) ##1 !busy;
   endproperty
   a_done: assert property (p_done) else $error("bad done");
   property p_time;
      op_done |-> cnt_q >= lim - 2 && cnt_q <= lim + 1210;
   endproperty
   a_time: assert property (p_time) else $error("bad duration");
   property p_rst;
      $fell(rst) |-> !busy && !op_start;
   endproperty
   a_rst: assert property (p_rst) else $error("not standby");
   c_start: cover property (op_start);
   c_done: cover property (op_done);
   c_err: cover property (pslverr);
endmodule
bind fwp_flash_protect fwp_props #(.PP_CYC(PP_CYC), .ER_CYC(ER_CYC), .CE_CYC(CE_CYC)) u_props (
   .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .op_start(op_start), .op_kind(op_kind), .op_done(op_done), .busy(busy));

//--- dv/fwp_host.sv
/* serial host model: chip select, clock and data.
   assumes the bench calls xfer with a right-aligned word. */
`timescale 1ns/10ps
module fwp_host (
   output logic cs_n,
   output logic sclk,
   output logic si
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // **********
   // mode 0 frame, msb first
   // **********
   task automatic xfer(input logic [2079:0] w, input int n);
      cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         si <= w[n - 1 - i];
         #100 sclk <= 1'b1;
         #100 sclk <= 1'b0;
      end
      #100 cs_n <= 1'b1;
      si <= ~si;
      #400;
   endtask
endmodule

//--- dv/testbench.sv
/* self-checking bench of the flash protect block.
   assumes the serial host model and the port checker. */
`timescale 1ns/10ps
module testbench;
   import fwp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic wp_n = 1'b1;
   logic sector_locked = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, cs_n, sclk, si, op_start, op_done, busy;
   fwp_op_t op_kind;
   logic [19:0] op_addr, a;
   logic [7:0] d;
   int n_errors = 0;
   int checked = 0;
   int seed = 51194;
   logic [64:0] rq[$];
   logic [22:0] oq[$];
   logic [64:0] r;
   logic [22:0] o;
   logic [67:0] tbl[5] = '{{16'h0004, 32'h1E002000, 20'hF0000},
      {16'h4004, 32'h00001E00, 20'h00000}, {16'h0044, 32'h1FE02000, 20'hFF000},
      {16'h0024, 32'h00000200, 20'h0F000}, {16'h0018, 32'h00002000, 20'h80000}};
   always #12.5 clk_sys = ~clk_sys;
   fwp_flash_protect #(.PP_CYC(2000), .ER_CYC(3000), .CE_CYC(4000)) dut (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cs_n(cs_n), .sclk(sclk), .si(si), .wp_n(wp_n), .sector_locked(sector_locked),
      .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done), .busy(busy));
   fwp_host host (.cs_n(cs_n), .sclk(sclk), .si(si));
   // ************
   // helpers
   // ************
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic summarize;
      if (n_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int k;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         chk("pready", 1, 0);
         summarize;
      end
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m,
                     input logic er);
      rq.push_back({er, m, e});
      apb(1'b0, ad, 32'h0);
   endtask
   task automatic wt(input int lim, input logic dn);
      int k;
      k = 0;
      while (k < lim && (dn ? op_done !== 1'b1 : busy !== 1'b0)) begin
         @(posedge clk_sys);
         k++;
      end
      if (k == lim) begin
         chk("wait", 1, 0);
         summarize;
      end
   endtask
   // ************
   // result watcher
   // ************
   always @(posedge clk_sys) begin
      if (pready === 1'b1 && pwrite === 1'b0 && rq.size() > 0) begin
         r = rq.pop_front();
         chk("prdata", r[31:0], prdata & r[63:32]);
         chk("pslverr", {31'h0, r[64]}, {31'h0, pslverr});
      end
      if (op_start === 1'b1) begin
         o = (oq.size() > 0) ? oq.pop_front() : 23'h7FFFFF;
         chk("op", {9'h0, o}, {9'h0, op_kind, op_addr});
      end
   end
   // ************
   // scenarios
   // ************
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      #150000;
      rd(A_STATUS, 32'h0, 32'hFFFFFFFF, 1'b0);
      rd(8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
      a = 20'(32'($random(seed)) & 32'h000FF000);
      host.xfer({C_SE, 4'h0, a}, 32);
      rd(A_EVENT, 32'h1, 32'h1, 1'b0);
      apb(1'b1, A_EVENT, 32'h3);
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      rd(A_STATUS, 32'h2, 32'h3, 1'b0);
      oq.push_back({OP_SE, a});
      host.xfer({C_SE, 4'h0, a}, 32);
      wt(4000, 1'b1);
      rd(A_STATUS, 32'h0, 32'h3, 1'b0);
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      host.xfer({1'b0, C_SE, 4'h0, a[19:1]}, 31);
      rd(A_EVENT, 32'h1, 32'h1, 1'b0);
      for (int i = 0; i < 5; i++) begin
         host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
         host.xfer({C_WRSR, tbl[i][59:52], tbl[i][67:60]}, 24);
         rd(A_PROT, tbl[i][51:20], 32'hFFFFFFFF, 1'b0);
         host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
         host.xfer({C_SE, 4'h0, tbl[i][19:0]}, 32);
      end
      wp_n <= 1'b0;
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      host.xfer({C_WRSR, 8'h00}, 16);
      rd(A_STATUS, 32'h18, 32'h1FC, 1'b0);
      wp_n <= 1'b1;
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      host.xfer({C_WRSR, 8'h00}, 16);
      rd(A_STATUS, 32'h0, 32'h1FC, 1'b0);
      apb(1'b1, A_CTRL, 32'h1);
      rd(A_CTRL, 32'h1, 32'h1, 1'b0);
      sector_locked <= 1'b1;
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      host.xfer({C_SE, 4'h0, a}, 32);
      sector_locked <= 1'b0;
      apb(1'b1, A_CTRL, 32'h0);
      d = 8'($random(seed));
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      oq.push_back({OP_PROG, 20'h00100});
      host.xfer({C_PP, 24'h000100, d}, 40);
      host.xfer(C_SUS, 8);
      wt(1300, 1'b0);
      rd(A_STATUS, 32'h00030000, 32'h00070001, 1'b0);
      host.xfer(C_RES, 8);
      wt(4000, 1'b1);
      host.xfer(C_DP, 8);
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      host.xfer(C_CE, 8);
      rd(A_STATUS, 32'h00040000, 32'h00070003, 1'b0);
      host.xfer(C_RDP, 8);
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      oq.push_back({OP_CE, 20'h00000});
      host.xfer(C_CE, 8);
      wt(6000, 1'b1);
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      host.xfer(C_WRDI, 8);
      rd(A_STATUS, 32'h0, 32'h3, 1'b0);
      a = 20'($random(seed));
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      oq.push_back({OP_B64, a[19:16], 16'h0});
      host.xfer({C_B64, 4'h0, a}, 32);
      wt(4000, 1'b1);
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      oq.push_back({OP_B32, a[19:15], 15'h0});
      host.xfer({C_B32, 4'h0, a}, 32);
      wt(4000, 1'b1);
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      oq.push_back({OP_PE, a[19:8], 8'h0});
      host.xfer({C_PE, 4'h0, a}, 32);
      wt(4000, 1'b1);
      host.xfer(C_SET_WRITE_ENABLE_CMD, 8);
      host.xfer({C_WRSR, 8'h04}, 16);
      rd(A_STATUS, 32'h4, 32'h1FC, 1'b0);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(A_STATUS, 32'h0, 32'hFFFFFFFF, 1'b0);
      repeat (4) @(posedge clk_sys);
      chk("queues", 32'h0, 32'(rq.size() + oq.size()));
      summarize;
   end
endmodule
